// ---- hdl/rfpg_pkg.sv ----
package rfpg_pkg;
  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] FAULT1_ADDR = 8'hA2;
  localparam logic [7:0] FAULT2_ADDR = 8'hA3;
  localparam logic [7:0] TREE1_ADDR = 8'hA4;
  localparam logic [7:0] TREE2_ADDR = 8'hA5;

  // ***************************************************************
  // Values after reset and writable bits
  // ***************************************************************
  localparam logic [7:0] FAULT1_RST = 8'h00;
  localparam logic [7:0] FAULT2_RST = 8'h20;
  localparam logic [7:0] TREE1_RST = 8'h00;
  localparam logic [7:0] TREE2_RST = 8'h00;
  localparam logic [7:0] ALL_RW = 8'hFF;
  localparam logic [7:0] FAULT2_RW = 8'h7F;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int FAULT2_RAILS = 5;
  localparam int TERM_REG_BIT = 3;
  localparam int RSV_ZERO_BIT = 6;
  localparam int RSV_ONE_BIT = 5;
  localparam int TREE2_CTRL_LSB = 4;
endpackage

// ---- hdl/rfpg_mask_reg.sv ----
`timescale 1ns/1ps
module rfpg_mask_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] RW_MASK = 8'hFF
) (
  input wire logic clk_i, // System clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic we_i, // Write strobe
  input wire logic [7:0] wdata_i, // Write data
  output logic [7:0] q_o // Stored value
);
  logic [7:0] val_d;
  logic [7:0] val_q;

  // Writable bits take new data, read-only bits hold reset value
  always_comb begin
    val_d = val_q;
    if (we_i) begin
      val_d = (wdata_i & RW_MASK) | (RST_VAL & ~RW_MASK);
    end
  end

  // Storage
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end

  assign q_o = val_q;
endmodule

// ---- hdl/rfpg_top.sv ----
`timescale 1ns/1ps
module rfpg_top (
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rstn_i, // Async reset, active low
  input wire logic reg_wr_i, // Register write strobe
  input wire logic reg_rd_i, // Register read strobe
  input wire logic [7:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Write data
  output logic [7:0] reg_rdata_o, // Read data, registered
  output logic reg_rvalid_o, // Read data valid pulse
  input wire logic [7:0] rail_fault1_i, // Faults of first rail group
  input wire logic [rfpg_pkg::FAULT2_RAILS-1:0] rail_fault2_i, // Second group
  output logic shutdown_o, // Unmasked fault present
  input wire logic [7:0] rail_pg1_i, // Power good, first rail group
  input wire logic [3:0] rail_pg2_i, // Power good, second rail group
  input wire logic [3:0] ctrl_in_i, // Control input pin states
  input wire logic out1_direct_i, // Output one under direct level control
  input wire logic out1_level_i, // Level used under direct control
  output logic pg_tree_good_o, // Output-one tree result, registered
  output logic status_out_one_o // Output pin one level
);
  import rfpg_pkg::*;

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic [7:0] fault1_mask;
  logic [7:0] fault2_mask;
  logic [7:0] tree1_mask;
  logic [7:0] tree2_mask;
  logic we_fault1;
  logic we_fault2;
  logic we_tree1;
  logic we_tree2;

  // Address decode of write strobes
  assign we_fault1 = reg_wr_i && (reg_addr_i == FAULT1_ADDR);
  assign we_fault2 = reg_wr_i && (reg_addr_i == FAULT2_ADDR);
  assign we_tree1 = reg_wr_i && (reg_addr_i == TREE1_ADDR);
  assign we_tree2 = reg_wr_i && (reg_addr_i == TREE2_ADDR);

  rfpg_mask_reg #(.RST_VAL(FAULT1_RST), .RW_MASK(ALL_RW)) u_fault1 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_fault1),
    .wdata_i(reg_wdata_i),
    .q_o(fault1_mask)
  );

  // Bit 7 reads zero; reserved 6 and 5 stay plain storage
  rfpg_mask_reg #(.RST_VAL(FAULT2_RST), .RW_MASK(FAULT2_RW)) u_fault2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_fault2),
    .wdata_i(reg_wdata_i),
    .q_o(fault2_mask)
  );

  rfpg_mask_reg #(.RST_VAL(TREE1_RST), .RW_MASK(ALL_RW)) u_tree1 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_tree1),
    .wdata_i(reg_wdata_i),
    .q_o(tree1_mask)
  );

  rfpg_mask_reg #(.RST_VAL(TREE2_RST), .RW_MASK(ALL_RW)) u_tree2 (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_tree2),
    .wdata_i(reg_wdata_i),
    .q_o(tree2_mask)
  );

  // ***************************************************************
  // Read port
  // ***************************************************************
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_d;
  logic rvalid_q;

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        FAULT1_ADDR: rdata_d = fault1_mask;
        FAULT2_ADDR: rdata_d = fault2_mask;
        TREE1_ADDR: rdata_d = tree1_mask;
        TREE2_ADDR: rdata_d = tree2_mask;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data and valid flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // ***************************************************************
  // Fault gating and power good tree
  // ***************************************************************
  logic [7:0] live_fault1;
  logic [FAULT2_RAILS-1:0] live_fault2;
  logic [15:0] tree_member;
  logic [15:0] tree_mask;
  logic shut_d;
  logic shut_q;
  logic tree_d;
  logic tree_q;
  logic out_d;
  logic out_q;

  // Masked faults drop out of the shutdown decision
  assign live_fault1 = rail_fault1_i & ~fault1_mask;
  assign live_fault2 = rail_fault2_i & ~fault2_mask[FAULT2_RAILS-1:0];

  // Tree members: control inputs high, then rails of both groups
  assign tree_member = {ctrl_in_i, rail_pg2_i, rail_pg1_i};
  assign tree_mask = {tree2_mask, tree1_mask};

  // Next values of shutdown, tree and output pin
  always_comb begin
    shut_d = (|live_fault1) || (|live_fault2);
    tree_d = &(tree_member | tree_mask);
    out_d = out1_direct_i ? out1_level_i : tree_d;
  end

  // Output flops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shut_q <= 1'b0;
      tree_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      shut_q <= shut_d;
      tree_q <= tree_d;
      out_q <= out_d;
    end
  end

  assign shutdown_o = shut_q;
  assign pg_tree_good_o = tree_q;
  assign status_out_one_o = out_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  fault1_mask_a: assert property (
    (rail_fault1_i != 8'h00 && (rail_fault1_i & ~fault1_mask) == 8'h00
     && live_fault2 == '0) |=> !shutdown_o)
    else $error("masked first-group fault caused shutdown");
  fault1_live_a: assert property (
    ((rail_fault1_i & ~fault1_mask) != 8'h00) |=> shutdown_o)
    else $error("unmasked first-group fault ignored");
  fault2_mask_a: assert property (
    ((rail_fault2_i & ~fault2_mask[4:0]) != 5'h00) |=> shutdown_o)
    else $error("unmasked second-group fault ignored");
  term_fault_a: assert property (
    (rail_fault2_i == 5'h08 && fault2_mask[3] && live_fault1 == 8'h00)
    |=> !shutdown_o)
    else $error("masked termination fault caused shutdown");
  tree_include_a: assert property (
    (!tree1_mask[0] && !rail_pg1_i[0]) |=> !pg_tree_good_o)
    else $error("included rail not bad in tree");
  tree_exclude_a: assert property (
    (tree1_mask == 8'hFF && (tree_member[15:8] | tree2_mask) == 8'hFF)
    |=> pg_tree_good_o)
    else $error("excluded rails still affect tree");
  tree_ctrl_a: assert property (
    (!tree2_mask[7] && !ctrl_in_i[3]) |=> !pg_tree_good_o)
    else $error("included control input ignored");
  out_follow_a: assert property (
    !out1_direct_i |=> (status_out_one_o == pg_tree_good_o))
    else $error("output pin does not follow tree");
  all_masked_a: assert property (
    (tree1_mask == 8'hFF && tree2_mask == 8'hFF) |=> pg_tree_good_o)
    else $error("fully masked tree not good");
  bit7_zero_a: assert property (
    reg_rvalid_o |-> $past(reg_addr_i) != FAULT2_ADDR || !reg_rdata_o[7])
    else $error("read-only bit 7 read as one");
  // Second-group masking and tree rail, direct level, reserved storage and read answer
  fault2_masked_a: assert property (
    (rail_fault2_i != 5'h00 && live_fault2 == '0 && live_fault1 == 8'h00)
    |=> !shutdown_o)
    else $error("masked second-group fault caused shutdown");
  tree_rail2_a: assert property (
    (!tree2_mask[0] && !rail_pg2_i[0]) |=> !pg_tree_good_o)
    else $error("included second-group rail ignored");
  out_direct_a: assert property (
    out1_direct_i |=> (status_out_one_o == $past(out1_level_i)))
    else $error("output pin does not take direct level");
  fault2_store_a: assert property (
    we_fault2 |=> (fault2_mask == ($past(reg_wdata_i) & FAULT2_RW)))
    else $error("second fault mask does not keep written bits");
  read_valid_a: assert property (
    reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe not answered");
  no_read_a: assert property (
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without strobe");

  shut_cov_c: cover property (!shutdown_o ##1 shutdown_o);
  tree_cov_c: cover property (pg_tree_good_o ##1 !pg_tree_good_o);
  direct_cov_c: cover property (out1_direct_i ##1 status_out_one_o);
  write_cov_c: cover property (we_fault2 ##1 fault2_mask[3]);
  level_cov_c: cover property (out1_direct_i && out1_level_i ##1 !tree_q);
endmodule

// ---- testbench/rfpg_host.sv ----
`timescale 1ns/1ps
module rfpg_host (
  input wire logic clk_i, // System clock
  input wire logic [7:0] rdata_i, // Read data
  input wire logic rvalid_i, // Read valid pulse
  output logic wr_o, // Write strobe
  output logic rd_o, // Read strobe
  output logic [7:0] addr_o, // Register address
  output logic [7:0] wdata_o // Write data
);
  import rfpg_pkg::*;
  // Bus idle from time zero
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One write strobe; reserved bits of the second fault mask kept legal
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    if (a == FAULT2_ADDR) begin
      d[RSV_ZERO_BIT] = 1'b0;
      d[RSV_ONE_BIT] = 1'b1;
    end
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a; // Released bus must not echo
    wdata_o = ~d;
  endtask
  // One read strobe; the answer is taken one cycle after the strobe
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end \
end
module testbench;
  import rfpg_pkg::*;
  logic clk_i, rstn_i, wr, rd, rv, sd, good, out1, direct, level;
  logic [7:0] addr, wdata, rdata, f1, p1;
  logic [4:0] f2;
  logic [3:0] p2, ci;
  int err_count = 0;
  int samples_checked = 0;
  // Clock of 20 ns
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Device and host
  rfpg_top i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rv), .rail_fault1_i(f1),
    .rail_fault2_i(f2), .shutdown_o(sd), .rail_pg1_i(p1),
    .rail_pg2_i(p2), .ctrl_in_i(ci), .out1_direct_i(direct),
    .out1_level_i(level), .pg_tree_good_o(good),
    .status_out_one_o(out1));
  rfpg_host i_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rv),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host.read(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  // Reset values, readback, read-only bit, unmapped place
  task automatic t_regs();
    rchk(FAULT1_ADDR, FAULT1_RST);
    rchk(FAULT2_ADDR, FAULT2_RST);
    rchk(TREE1_ADDR, TREE1_RST);
    rchk(TREE2_ADDR, TREE2_RST);
    i_host.write(8'hA6, 8'hFF);
    rchk(8'hA6, 8'h00);
    i_host.write(FAULT1_ADDR, 8'hA5);
    rchk(FAULT1_ADDR, 8'hA5);
    i_host.write(FAULT2_ADDR, 8'hFF);
    rchk(FAULT2_ADDR, 8'h3F);
    i_host.write(TREE1_ADDR, 8'h5A);
    rchk(TREE1_ADDR, 8'h5A);
    i_host.write(TREE2_ADDR, 8'hC3);
    rchk(TREE2_ADDR, 8'hC3);
    i_host.write(FAULT1_ADDR, 8'h00);
    i_host.write(FAULT2_ADDR, 8'h00);
    i_host.write(TREE1_ADDR, 8'h00);
    i_host.write(TREE2_ADDR, 8'h00);
    rchk(FAULT2_ADDR, 8'h20);
    $display("test regs done");
  endtask
  // Each rail fault shuts down unless its mask bit is set
  task automatic t_fault();
    logic [7:0] a;
    for (int i = 0; i < 13; i++) begin
      a = (i < 8) ? FAULT1_ADDR : FAULT2_ADDR;
      {f2, f1} = 13'h1 << i;
      settle();
      `CHK("shutdown", 1'b1, sd)
      i_host.write(a, 8'h1 << (i % 8));
      settle();
      `CHK("shutdown", 1'b0, sd)
      i_host.write(a, 8'h00);
      {f2, f1} = 13'h0;
    end
    $display("test fault done");
  endtask
  // Each tree member pulls the tree low unless excluded
  task automatic t_tree();
    logic [7:0] a;
    {ci, p2, p1} = 16'hFFFF;
    settle();
    `CHK("tree", 1'b1, good)
    for (int i = 0; i < 16; i++) begin
      a = (i < 8) ? TREE1_ADDR : TREE2_ADDR;
      {ci, p2, p1} = ~(16'h1 << i);
      settle();
      `CHK("tree", 1'b0, good)
      `CHK("out1", 1'b0, out1)
      i_host.write(a, 8'h1 << (i % 8));
      settle();
      `CHK("tree", 1'b1, good)
      i_host.write(a, 8'h00);
    end
    {ci, p2, p1} = 16'h0;
    i_host.write(TREE1_ADDR, 8'hFF);
    i_host.write(TREE2_ADDR, 8'hFF);
    settle();
    `CHK("tree", 1'b1, good)
    `CHK("out1", 1'b1, out1)
    direct = 1'b1;
    settle();
    `CHK("out1", 1'b0, out1)
    level = 1'b1;
    i_host.write(TREE1_ADDR, 8'h00);
    settle();
    `CHK("tree", 1'b0, good)
    `CHK("out1", 1'b1, out1)
    $display("test tree done");
  endtask
  // Reset in mid-run clears outputs and brings back reset values
  task automatic t_reset();
    i_host.write(FAULT1_ADDR, 8'hFF);
    f1 = 8'h01;
    settle();
    `CHK("shutdown", 1'b0, sd)
    rstn_i = 1'b0;
    @(negedge clk_i);
    `CHK("shutdown", 1'b0, sd)
    `CHK("out1", 1'b0, out1)
    rstn_i = 1'b1;
    settle();
    `CHK("shutdown", 1'b1, sd)
    `CHK("out1", 1'b1, out1)
    rchk(FAULT1_ADDR, FAULT1_RST);
    rchk(TREE2_ADDR, TREE2_RST);
    f1 = 8'h00;
    $display("test reset done");
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    {f2, f1, ci, p2, p1} = 29'h0;
    direct = 1'b0;
    level = 1'b0;
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    t_regs();
    t_fault();
    t_tree();
    t_reset();
    end_sim();
  end
endmodule
